// ==== core/dtp_regs.svh ====
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH

// register byte offsets
`define DTP_RUN_OFS 5'h00
`define DTP_MODE_OFS 5'h04
`define DTP_FFCR_OFS 5'h08
`define DTP_LCMP_OFS 5'h0c
`define DTP_UCMP_OFS 5'h10
`define DTP_STAT_OFS 5'h14

// run_control_reg fields
`define DTP_RUN_LOWER_BIT 0
`define DTP_RUN_UPPER_BIT 1
`define DTP_RUN_PRESCALE_BIT 2
`define DTP_RUN_DBUF_BIT 7

// timer_mode_reg fields
`define DTP_MODE_HI 7
`define DTP_MODE_LO 6
`define DTP_PWM_HI 5
`define DTP_PWM_LO 4
`define DTP_UCLK_HI 3
`define DTP_UCLK_LO 2
`define DTP_LCLK_HI 1
`define DTP_LCLK_LO 0

// flipflop_control_reg fields
`define DTP_PRESET_HI 3
`define DTP_PRESET_LO 2
`define DTP_INV_EN_BIT 1
`define DTP_TSRC_BIT 0
`define DTP_PRESET_CLEAR 2'h2
`define DTP_PRESET_SET 2'h1
`define DTP_PRESET_NONE 2'h3

// status register fields
`define DTP_STAT_FF_BIT 16

// reset values
`define DTP_RUN_RST 8'h00
`define DTP_MODE_RST 8'h00
`define DTP_FFCR_RST 2'h0
`define DTP_CMP_RST 8'h00

// pwm overflow lengths
`define DTP_OVF_64 9'h040
`define DTP_OVF_128 9'h080
`define DTP_OVF_256 9'h100

`endif

// ==== core/dtp_pkg.sv ====
package dtp_pkg;
    typedef enum logic [1:0] {
        DTP_MODE_DUAL,
        DTP_MODE_CASCADE,
        DTP_MODE_PPG,
        DTP_MODE_PWM
    } dtp_mode_t;
    typedef enum logic [1:0] {
        DTP_CLK_EXT_OR_CHAIN,
        DTP_CLK_TAP_A,
        DTP_CLK_TAP_B,
        DTP_CLK_TAP_C
    } dtp_clk_sel_t;
endpackage : dtp_pkg

// ==== core/dtp_tick_if.sv ====
`timescale 1ns/1ps
interface dtp_tick_if;
    logic prescale_run;
    logic prescale_tap_div2;
    logic prescale_tap_div8;
    logic prescale_tap_div32;
    logic prescale_tap_div512;
    logic ext_tick;
    modport src (
        input prescale_run,
        output prescale_tap_div2,
        output prescale_tap_div8,
        output prescale_tap_div32,
        output prescale_tap_div512,
        output ext_tick
    );
    modport snk (
        output prescale_run,
        input prescale_tap_div2,
        input prescale_tap_div8,
        input prescale_tap_div32,
        input prescale_tap_div512,
        input ext_tick
    );
endinterface : dtp_tick_if

// ==== core/dtp_prescale.sv ====
`timescale 1ns/1ps
module dtp_prescale #(
    parameter int DIV_W = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic count_in,
    dtp_tick_if.src ticks
);
    if (DIV_W < 9) begin : g_check
        $error("dtp_prescale: DIV_W must be at least 9");
    end

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic [3:0] tap_reg;
    logic [3:0] tap_next;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic ext_reg;
    logic ext_next;

    // each tap pulses for one cycle when its low divider bits are all ones
    always_comb begin
        div_next = ticks.prescale_run ? div_reg + DIV_W'(1) : '0;
        tap_next[0] = ticks.prescale_run & div_reg[0];
        tap_next[1] = ticks.prescale_run & (&div_reg[2:0]);
        tap_next[2] = ticks.prescale_run & (&div_reg[4:0]);
        tap_next[3] = ticks.prescale_run & (&div_reg[8:0]);
        ext_next = sync2_reg & ~sync3_reg;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
            tap_reg <= 4'h0;
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            ext_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tap_reg <= tap_next;
            sync1_reg <= count_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            ext_reg <= ext_next;
        end
    end

    assign ticks.prescale_tap_div2 = tap_reg[0];
    assign ticks.prescale_tap_div8 = tap_reg[1];
    assign ticks.prescale_tap_div32 = tap_reg[2];
    assign ticks.prescale_tap_div512 = tap_reg[3];
    assign ticks.ext_tick = ext_reg;
endmodule : dtp_prescale

// ==== core/dtp_timer.sv ====
// Contract
// - compare values 01h..ffh count as written, 00h counts as 256; the upper compare in cascade mode counts 00h as 0.
// - compare value 00h matches when the 8-bit counter overflows; the upper compare in cascade mode matches 00h at an upper count of 0.
// - pwm exists only on the lower timer, never on the upper.
// - in pwm mode the waveform leaves through the output flip-flop.
// - in pwm mode the upper timer still runs as an interval timer.
// - pwm toggles flip-flop on lower match and on 2^n overflow.
// - pwm clears the lower counter on every 2^n overflow.
// - pwm with double buffer loads buffered compare on 2^n overflow.
// - mode field: 00 dual, 01 cascade 16-bit, 10 pulse gen, 11 pwm.
// - pwm period field: 01 is 2^6, 10 is 2^7, 11 is 2^8.
// - lower clock select: 00 external, 01/10/11 divide 2/8/32.
// - upper clock in pwm mode: divide 2/32/512; upper has no output.
// - dual mode: upper may count lower matches; source bit picks toggler.
// - run control bit 7 enables the lower compare double buffer.
// - preset 10 clears the flip-flop, preset 01 sets it.
// - pulse gen toggles the flip-flop on lower or upper compare match.
// - pulse gen with double buffer loads buffer on upper match.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_timer #(
    parameter int ADDR_W = 5,
    parameter int DIV_W = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic count_in,
    output logic timer_output_pin
);
    if (ADDR_W < 5) begin : g_check
        $error("dtp_timer: ADDR_W must be at least 5");
    end

    dtp_tick_if ticks ();

    dtp_prescale #(
        .DIV_W(DIV_W)
    ) u_prescale (
        .mclk(mclk),
        .rst(rst),
        .count_in(count_in),
        .ticks(ticks.src)
    );

    // software visible state
    logic [7:0] run_control_reg;
    logic [7:0] run_control_next;
    logic [7:0] timer_mode_reg;
    logic [7:0] timer_mode_next;
    logic [1:0] flipflop_control_reg;
    logic [1:0] flipflop_control_next;
    logic [7:0] lower_compare_reg;
    logic [7:0] lower_compare_next;
    logic [7:0] lower_buffer_reg;
    logic [7:0] lower_buffer_next;
    logic [7:0] upper_compare_reg;
    logic [7:0] upper_compare_next;

    // timer state
    logic [7:0] lower_up_counter_reg;
    logic [7:0] lower_up_counter_next;
    logic [7:0] upper_counter_reg;
    logic [7:0] upper_counter_next;
    logic output_flipflop_reg;
    logic output_flipflop_next;

    // bus state
    logic wait_reg;
    logic wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // decoded fields and events
    dtp_pkg::dtp_mode_t mode;
    dtp_pkg::dtp_clk_sel_t lower_clock_select;
    dtp_pkg::dtp_clk_sel_t upper_clock_select;
    logic [1:0] pwm_period_field;
    logic dbuf_en;
    logic lower_run;
    logic upper_run;
    logic inv_en;
    logic toggle_source_select;
    logic lower_tick;
    logic upper_tick;
    logic [8:0] lower_inc;
    logic [8:0] upper_inc;
    logic [8:0] lower_cmp_eff;
    logic [8:0] upper_cmp_eff;
    logic [8:0] pwm_ovf_len;
    logic lower_hit;
    logic upper_hit;
    logic lower_ovf;
    logic pwm_ovf;
    logic upper_vs_lower;
    logic toggle;
    logic dbuf_load;
    logic bus_take;
    logic [1:0] preset;

    assign mode = dtp_pkg::dtp_mode_t'(timer_mode_reg[`DTP_MODE_HI:`DTP_MODE_LO]);
    assign pwm_period_field = timer_mode_reg[`DTP_PWM_HI:`DTP_PWM_LO];
    assign lower_clock_select = dtp_pkg::dtp_clk_sel_t'(timer_mode_reg[`DTP_LCLK_HI:`DTP_LCLK_LO]);
    assign upper_clock_select = dtp_pkg::dtp_clk_sel_t'(timer_mode_reg[`DTP_UCLK_HI:`DTP_UCLK_LO]);
    assign dbuf_en = run_control_reg[`DTP_RUN_DBUF_BIT];
    assign lower_run = run_control_reg[`DTP_RUN_LOWER_BIT];
    assign upper_run = run_control_reg[`DTP_RUN_UPPER_BIT];
    assign inv_en = flipflop_control_reg[1];
    assign toggle_source_select = flipflop_control_reg[0];
    assign ticks.prescale_run = run_control_reg[`DTP_RUN_PRESCALE_BIT];
    assign bus_take = (avs_read | avs_write) & ~wait_reg;

    // count clock selection
    always_comb begin
        unique case (lower_clock_select)
            dtp_pkg::DTP_CLK_EXT_OR_CHAIN: lower_tick = ticks.ext_tick;
            dtp_pkg::DTP_CLK_TAP_A: lower_tick = ticks.prescale_tap_div2;
            dtp_pkg::DTP_CLK_TAP_B: lower_tick = ticks.prescale_tap_div8;
            dtp_pkg::DTP_CLK_TAP_C: lower_tick = ticks.prescale_tap_div32;
        endcase
        lower_tick = lower_tick & lower_run;
    end

    // a compare value of zero stands for 256, reached as the counter wraps
    always_comb begin
        lower_inc = {1'b0, lower_up_counter_reg} + 9'h001;
        upper_inc = {1'b0, upper_counter_reg} + 9'h001;
        lower_cmp_eff = {(lower_compare_reg == 8'h00), lower_compare_reg};
        upper_cmp_eff = {(upper_compare_reg == 8'h00), upper_compare_reg};
        lower_hit = lower_tick & (lower_inc == lower_cmp_eff);
        lower_ovf = lower_tick & lower_inc[8];
        unique case (pwm_period_field)
            2'h1: pwm_ovf_len = `DTP_OVF_64;
            2'h2: pwm_ovf_len = `DTP_OVF_128;
            default: pwm_ovf_len = `DTP_OVF_256;
        endcase
        pwm_ovf = lower_tick & (lower_inc == pwm_ovf_len);
        upper_vs_lower = lower_tick & (lower_inc == upper_cmp_eff);
    end

    // upper count source: lower overflow in cascade mode, else chained event on code 00 or prescaler taps
    always_comb begin
        unique case (upper_clock_select)
            dtp_pkg::DTP_CLK_EXT_OR_CHAIN: upper_tick = lower_hit;
            dtp_pkg::DTP_CLK_TAP_A: upper_tick = ticks.prescale_tap_div2;
            dtp_pkg::DTP_CLK_TAP_B: upper_tick = ticks.prescale_tap_div32;
            dtp_pkg::DTP_CLK_TAP_C: upper_tick = ticks.prescale_tap_div512;
        endcase
        if (mode == dtp_pkg::DTP_MODE_CASCADE) begin
            upper_tick = lower_ovf;
        end
        upper_tick = upper_tick & upper_run;
        upper_hit = upper_tick & (upper_inc == upper_cmp_eff);
    end

    // counters, flip-flop and double buffer
    always_comb begin
        lower_up_counter_next = lower_tick ? lower_inc[7:0] : lower_up_counter_reg;
        upper_counter_next = upper_tick ? upper_inc[7:0] : upper_counter_reg;
        toggle = 1'b0;
        dbuf_load = 1'b0;
        unique case (mode)
            dtp_pkg::DTP_MODE_DUAL: begin
                if (lower_hit) begin
                    lower_up_counter_next = 8'h00;
                end
                if (upper_hit) begin
                    upper_counter_next = 8'h00;
                end
                toggle = toggle_source_select ? upper_hit : lower_hit;
            end
            dtp_pkg::DTP_MODE_CASCADE: begin
                // both halves must agree before the 16-bit period ends
                if (lower_hit && (upper_counter_reg == upper_compare_reg)) begin
                    lower_up_counter_next = 8'h00;
                    upper_counter_next = 8'h00;
                    toggle = 1'b1;
                end
            end
            dtp_pkg::DTP_MODE_PPG: begin
                toggle = lower_hit | upper_vs_lower;
                if (upper_vs_lower) begin
                    lower_up_counter_next = 8'h00;
                    dbuf_load = dbuf_en;
                end
            end
            dtp_pkg::DTP_MODE_PWM: begin
                // only the lower timer shapes the pin; upper stays an interval timer
                toggle = lower_hit | pwm_ovf;
                if (pwm_ovf) begin
                    lower_up_counter_next = 8'h00;
                    dbuf_load = dbuf_en;
                end
                if (upper_hit) begin
                    upper_counter_next = 8'h00;
                end
            end
        endcase
        if (!lower_run) begin
            lower_up_counter_next = 8'h00;
        end
        if (!upper_run) begin
            upper_counter_next = 8'h00;
        end
        output_flipflop_next = output_flipflop_reg;
        if (toggle && inv_en) begin
            output_flipflop_next = ~output_flipflop_reg;
        end
        preset = `DTP_PRESET_NONE;
        if (bus_take && avs_write && (avs_address[4:0] == `DTP_FFCR_OFS)) begin
            preset = avs_writedata[`DTP_PRESET_HI:`DTP_PRESET_LO];
        end
        if (preset == `DTP_PRESET_CLEAR) begin
            output_flipflop_next = 1'b0;
        end else if (preset == `DTP_PRESET_SET) begin
            output_flipflop_next = 1'b1;
        end
    end

    // register file and avalon slave
    always_comb begin
        run_control_next = run_control_reg;
        timer_mode_next = timer_mode_reg;
        flipflop_control_next = flipflop_control_reg;
        lower_compare_next = lower_compare_reg;
        lower_buffer_next = lower_buffer_reg;
        upper_compare_next = upper_compare_reg;
        rdata_next = rdata_reg;
        wait_next = ~((avs_read | avs_write) & wait_reg);
        if (dbuf_load) begin
            lower_compare_next = lower_buffer_reg;
        end
        if (avs_read && wait_reg) begin
            rdata_next = 32'h0000_0000;
            unique case (avs_address[4:0])
                `DTP_RUN_OFS: rdata_next[7:0] = run_control_reg;
                `DTP_MODE_OFS: rdata_next[7:0] = timer_mode_reg;
                `DTP_FFCR_OFS: rdata_next[3:0] = {`DTP_PRESET_NONE, flipflop_control_reg};
                `DTP_LCMP_OFS: rdata_next[7:0] = lower_compare_reg;
                `DTP_UCMP_OFS: rdata_next[7:0] = upper_compare_reg;
                `DTP_STAT_OFS: rdata_next[16:0] = {output_flipflop_reg, upper_counter_reg, lower_up_counter_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (bus_take && avs_write) begin
            unique case (avs_address[4:0])
                `DTP_RUN_OFS: run_control_next = avs_writedata[7:0];
                `DTP_MODE_OFS: timer_mode_next = avs_writedata[7:0];
                `DTP_FFCR_OFS: flipflop_control_next = avs_writedata[1:0];
                `DTP_LCMP_OFS: begin
                    lower_buffer_next = avs_writedata[7:0];
                    if (!dbuf_en) begin
                        lower_compare_next = avs_writedata[7:0];
                    end
                end
                `DTP_UCMP_OFS: upper_compare_next = avs_writedata[7:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_control_reg <= `DTP_RUN_RST;
            timer_mode_reg <= `DTP_MODE_RST;
            flipflop_control_reg <= `DTP_FFCR_RST;
            lower_compare_reg <= `DTP_CMP_RST;
            lower_buffer_reg <= `DTP_CMP_RST;
            upper_compare_reg <= `DTP_CMP_RST;
            lower_up_counter_reg <= 8'h00;
            upper_counter_reg <= 8'h00;
            output_flipflop_reg <= 1'b0;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            run_control_reg <= run_control_next;
            timer_mode_reg <= timer_mode_next;
            flipflop_control_reg <= flipflop_control_next;
            lower_compare_reg <= lower_compare_next;
            lower_buffer_reg <= lower_buffer_next;
            upper_compare_reg <= upper_compare_next;
            lower_up_counter_reg <= lower_up_counter_next;
            upper_counter_reg <= upper_counter_next;
            output_flipflop_reg <= output_flipflop_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign timer_output_pin = output_flipflop_reg;
endmodule : dtp_timer

// ==== dv/dtp_load.sv ====
`timescale 1ns/1ps
module dtp_load (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin,
    output int rises,
    output int hi_len,
    output int per_len
);
    int cyc;
    int last_rise;
    logic pin_q;
    // measures the waveform that the output pin drives into its load
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cyc = 0;
            last_rise = 0;
            pin_q = 1'b0;
            rises <= 0;
        end else begin
            cyc = cyc + 1;
            if (pin === 1'b1 && pin_q === 1'b0) begin
                per_len <= cyc - last_rise;
                last_rise = cyc;
                rises <= rises + 1;
            end
            if (pin === 1'b0 && pin_q === 1'b1) hi_len <= cyc - last_rise;
            pin_q = pin;
        end
    end
endmodule : dtp_load

// ==== dv/dtp_timer_props.sv ====
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_timer_props #(
    parameter int ADDR_W = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic count_in,
    input wire logic timer_output_pin
);
    logic wr_ok;
    logic rd_ok;
    logic [1:0] ff_reg;
    logic ffwr_reg;
    logic dbuf_reg;
    logic lval_reg;
    logic [7:0] lcmp_reg;
    assign wr_ok = avs_write && !avs_waitrequest;
    assign rd_ok = avs_read && !avs_waitrequest;
    // shadow of what software last wrote
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ff_reg <= 2'h0;
            ffwr_reg <= 1'b0;
            dbuf_reg <= 1'b0;
            lval_reg <= 1'b1;
            lcmp_reg <= 8'h00;
        end else begin
            ffwr_reg <= wr_ok && avs_address == `DTP_FFCR_OFS;
            if (wr_ok && avs_address == `DTP_FFCR_OFS) ff_reg <= avs_writedata[1:0];
            if (wr_ok && avs_address == `DTP_RUN_OFS) begin
                dbuf_reg <= avs_writedata[7];
                if (avs_writedata[7]) lval_reg <= 1'b0;
            end
            if (wr_ok && avs_address == `DTP_LCMP_OFS && !dbuf_reg) begin
                lcmp_reg <= avs_writedata[7:0];
                lval_reg <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence ack_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    wait_one_a: assert property (req_s |=> ack_s) else $error("bus answer not after one wait");
    idle_wait_a: assert property (!avs_read && !avs_write |-> avs_waitrequest) else $error("ready while idle");
    unmapped_rd_a: assert property (rd_ok && avs_address > `DTP_STAT_OFS |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rd_ok |-> avs_readdata[31:17] == 15'h0) else $error("upper read bits set");
    ffcr_read_a: assert property (rd_ok && avs_address == `DTP_FFCR_OFS |->
        avs_readdata[3:0] == {2'h3, ff_reg}) else $error("flip-flop control readback wrong");
    lcmp_read_a: assert property (rd_ok && avs_address == `DTP_LCMP_OFS && lval_reg |->
        avs_readdata[7:0] == lcmp_reg) else $error("direct compare write not active");
    preset_clr_a: assert property (wr_ok && avs_address == `DTP_FFCR_OFS &&
        avs_writedata[3:2] == `DTP_PRESET_CLEAR |=> !timer_output_pin) else $error("preset clear failed");
    preset_set_a: assert property (wr_ok && avs_address == `DTP_FFCR_OFS &&
        avs_writedata[3:2] == `DTP_PRESET_SET |=> timer_output_pin) else $error("preset set failed");
    inv_gate_a: assert property (!ff_reg[1] && !ffwr_reg |-> $stable(timer_output_pin))
        else $error("pin toggled with inversion off");
endmodule : dtp_timer_props
bind dtp_timer dtp_timer_props #(.ADDR_W(ADDR_W)) u_props (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .count_in(count_in), .timer_output_pin(timer_output_pin));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "dtp_regs.svh"
module tb_top;
    typedef struct {logic [7:0] mode; logic [7:0] lcmp; logic [7:0] ucmp; logic [7:0] ffcr;
        logic [7:0] run; int hi; int per;} dtp_row_t;
    dtp_row_t rows [12];
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic count_in = 1'b0;
    logic [1:0] div_reg = 2'h0;
    logic timer_output_pin;
    logic [31:0] rd;
    logic [31:0] s1;
    int rises;
    int hi_len;
    int per_len;
    int bad_count = 0;
    int checks = 0;
    dtp_timer #(.ADDR_W(5), .DIV_W(9)) DUT (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_in(count_in),
        .timer_output_pin(timer_output_pin));
    dtp_load load (.mclk(mclk), .rst(rst), .pin(timer_output_pin), .rises(rises), .hi_len(hi_len),
        .per_len(per_len));
    initial begin
        forever #50 mclk = ~mclk;
    end
    // external count input: period of 8 mclk
    always @(posedge mclk) begin
        div_reg <= div_reg + 2'h1;
        if (div_reg == 2'h3) count_in <= ~count_in;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) bad_count++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus_xfer
    task wait_rises(input int n);
        int r0;
        int t;
        r0 = rises;
        t = 0;
        while (rises < r0 + n && t < 20000) begin
            @(posedge mclk);
            t++;
        end
        if (t >= 20000) bad_count++;
    endtask : wait_rises
    task results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        results();
    end
    initial begin
        // compare values obey the software limits of each mode
        rows[0] = '{8'hd1, 8'h10, 8'h00, 8'h0a, 8'h05, 96, 128};
        rows[1] = '{8'he1, 8'h10, 8'h00, 8'h0a, 8'h05, 224, 256};
        rows[2] = '{8'hf1, 8'h10, 8'h00, 8'h0a, 8'h05, 480, 512};
        rows[3] = '{8'hd2, 8'h10, 8'h00, 8'h0a, 8'h05, 384, 512};
        rows[4] = '{8'hd3, 8'h10, 8'h00, 8'h0a, 8'h05, 1536, 2048};
        rows[5] = '{8'hd0, 8'h10, 8'h00, 8'h0a, 8'h05, 384, 512};
        rows[6] = '{8'h01, 8'h03, 8'h00, 8'h0a, 8'h05, 6, 12};
        rows[7] = '{8'h01, 8'h00, 8'h00, 8'h0a, 8'h05, 512, 1024};
        rows[8] = '{8'h81, 8'h0d, 8'h32, 8'h0a, 8'h07, 74, 100};
        rows[9] = '{8'h01, 8'h02, 8'h03, 8'h0b, 8'h07, 12, 24};
        rows[10] = '{8'hd1, 8'h10, 8'h00, 8'h06, 8'h05, 32, 128};
        rows[11] = '{8'h41, 8'h04, 8'h01, 8'h0a, 8'h07, 520, 1040};
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            bus_xfer(1'b1, `DTP_RUN_OFS, 8'h00, rd);
            bus_xfer(1'b1, `DTP_MODE_OFS, rows[i].mode, rd);
            bus_xfer(1'b1, `DTP_LCMP_OFS, rows[i].lcmp, rd);
            bus_xfer(1'b1, `DTP_UCMP_OFS, rows[i].ucmp, rd);
            bus_xfer(1'b1, `DTP_FFCR_OFS, rows[i].ffcr, rd);
            bus_xfer(1'b1, `DTP_RUN_OFS, rows[i].run, rd);
            wait_rises(3);
            check(hi_len, rows[i].hi);
            check(per_len, rows[i].per);
            $display("test %0d done", i);
        end
        // buffered compare only moves at the period end
        bus_xfer(1'b1, `DTP_RUN_OFS, 8'h00, rd);
        bus_xfer(1'b1, `DTP_MODE_OFS, 8'hd1, rd);
        bus_xfer(1'b1, `DTP_LCMP_OFS, 8'h10, rd);
        bus_xfer(1'b1, `DTP_FFCR_OFS, 8'h0a, rd);
        bus_xfer(1'b1, `DTP_RUN_OFS, 8'h85, rd);
        wait_rises(2);
        bus_xfer(1'b1, `DTP_LCMP_OFS, 8'h20, rd);
        bus_xfer(1'b0, `DTP_LCMP_OFS, 8'h00, rd);
        check(rd, 32'h00000010);
        wait_rises(3);
        check(hi_len, 64);
        bus_xfer(1'b0, `DTP_LCMP_OFS, 8'h00, rd);
        check(rd, 32'h00000020);
        $display("test buffer done");
        // pulse gen: buffered compare moves on the upper match
        bus_xfer(1'b1, `DTP_RUN_OFS, 8'h00, rd);
        bus_xfer(1'b1, `DTP_MODE_OFS, 8'h81, rd);
        bus_xfer(1'b1, `DTP_LCMP_OFS, 8'h0d, rd);
        bus_xfer(1'b1, `DTP_UCMP_OFS, 8'h32, rd);
        bus_xfer(1'b1, `DTP_FFCR_OFS, 8'h0a, rd);
        bus_xfer(1'b1, `DTP_RUN_OFS, 8'h87, rd);
        wait_rises(2);
        bus_xfer(1'b1, `DTP_LCMP_OFS, 8'h19, rd);
        bus_xfer(1'b0, `DTP_LCMP_OFS, 8'h00, rd);
        check(rd, 32'h0000000d);
        wait_rises(3);
        check(hi_len, 50);
        check(per_len, 100);
        $display("test ppg buffer done");
        bus_xfer(1'b1, `DTP_RUN_OFS, 8'h00, rd);
        bus_xfer(1'b0, `DTP_STAT_OFS, 8'h00, rd);
        check({16'h0, rd[15:0]}, 32'h0);
        // upper timer keeps counting beside the pwm output
        bus_xfer(1'b1, `DTP_UCMP_OFS, 8'h00, rd);
        bus_xfer(1'b1, `DTP_MODE_OFS, 8'hd5, rd);
        bus_xfer(1'b1, `DTP_RUN_OFS, 8'h07, rd);
        bus_xfer(1'b0, `DTP_STAT_OFS, 8'h00, s1);
        repeat (40) @(posedge mclk);
        bus_xfer(1'b0, `DTP_STAT_OFS, 8'h00, rd);
        // upper ticks every 2 mclk: 21 ticks lie between the two status samples
        check({24'h0, rd[15:8] - s1[15:8]}, 32'h00000015);
        $display("test upper done");
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            bus_xfer(1'b0, 5'(k * 4), 8'h00, rd);
            check(rd, (k == 2) ? 32'h0000000c : 32'h00000000);
        end
        $display("test reset done");
        results();
    end
endmodule : tb_top
